// file: rtl/tap_pkg.sv
/*
 * Shared constants for the test access port instruction unit: instruction codes
 * for both register widths, capture pattern layout, TAP states and reset values.
 * Assumes nothing of its surroundings.
 */
package tap_pkg;

	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_IDLE = 4'h1,
		ST_SEL_DR = 4'h2,
		ST_CAP_DR = 4'h3,
		ST_SHIFT_DR = 4'h4,
		ST_EXIT1_DR = 4'h5,
		ST_PAUSE_DR = 4'h6,
		ST_EXIT2_DR = 4'h7,
		ST_UPD_DR = 4'h8,
		ST_SEL_IR = 4'h9,
		ST_CAP_IR = 4'ha,
		ST_SHIFT_IR = 4'hb,
		ST_EXIT1_IR = 4'hc,
		ST_PAUSE_IR = 4'hd,
		ST_EXIT2_IR = 4'he,
		ST_UPD_IR = 4'hf
	} tap_state_t;

	typedef enum logic [2:0] {
		OP_BYPASS = 3'h0,
		OP_SAMPLE = 3'h1,
		OP_EXTEST = 3'h2,
		OP_CLAMP = 3'h3,
		OP_HIGHZ = 3'h4,
		OP_IDCODE = 3'h5,
		OP_USER_CODE_REGISTER = 3'h6,
		OP_CONFIG = 3'h7
	} tap_op_t;

	// Low byte of every instruction; wide codes add 8'h00 above (bypass 8'hff)
	localparam logic [7:0] CODE_BYPASS = 8'hff;
	localparam logic [7:0] CODE_SAMPLE = 8'h01;
	localparam logic [7:0] CODE_EXTEST = 8'h00;
	localparam logic [7:0] CODE_CLAMP = 8'hfa;
	localparam logic [7:0] CODE_HIGHZ = 8'hfc;
	localparam logic [7:0] CODE_IDCODE = 8'hfe;
	localparam logic [7:0] CODE_USER_CODE_REGISTER = 8'hfd;
	localparam logic [7:0] CODE_CONFIG = 8'hee;

	localparam logic [1:0] CAP_LSB_PATTERN = 2'h1;
	localparam logic [1:0] RESULT_PASS = 2'h2;
	localparam logic [1:0] RESULT_FAIL = 2'h1;
	localparam logic [31:0] USER_CODE_BLANK = 32'hffffffff;
	// Arbitrary neutral identification value; bit 0 forced to 1 in logic
	localparam logic [31:0] ID_CODE_DEFAULT = 32'h0a5a5001;
	localparam logic [1:0] REV_RESET = 2'h0;

	localparam int unsigned SYNC_STAGES = 2;

endpackage : tap_pkg

// file: rtl/pin_sync.sv
/*
 * Two-flop synchroniser for a bundle of pin levels.
 * Assumes inputs are asynchronous to clk_i; output is a level in clk_i domain.
 */
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule : pin_sync

// file: rtl/tap_fsm.sv
/*
 * Sixteen-state test access port controller, advanced on a TCK rise strobe.
 * Assumes tms_i and tck_rise_i are already synchronised to clk_i.
 */
`timescale 1ns/10ps
module tap_fsm (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tck_rise_i,
	input wire logic tms_i,
	output tap_pkg::tap_state_t state_o
);
	tap_pkg::tap_state_t state_nxt;

	always_comb begin
		state_nxt = state_o;
		unique case (state_o)
			tap_pkg::ST_RESET: state_nxt = tms_i ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
			tap_pkg::ST_IDLE: state_nxt = tms_i ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
			tap_pkg::ST_SEL_DR: state_nxt = tms_i ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
			tap_pkg::ST_CAP_DR: state_nxt = tms_i ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
			tap_pkg::ST_SHIFT_DR: state_nxt = tms_i ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
			tap_pkg::ST_EXIT1_DR: state_nxt = tms_i ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
			tap_pkg::ST_PAUSE_DR: state_nxt = tms_i ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
			tap_pkg::ST_EXIT2_DR: state_nxt = tms_i ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
			tap_pkg::ST_UPD_DR: state_nxt = tms_i ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
			tap_pkg::ST_SEL_IR: state_nxt = tms_i ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
			tap_pkg::ST_CAP_IR: state_nxt = tms_i ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
			tap_pkg::ST_SHIFT_IR: state_nxt = tms_i ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
			tap_pkg::ST_EXIT1_IR: state_nxt = tms_i ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
			tap_pkg::ST_PAUSE_IR: state_nxt = tms_i ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
			tap_pkg::ST_EXIT2_IR: state_nxt = tms_i ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
			tap_pkg::ST_UPD_IR: state_nxt = tms_i ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_o <= tap_pkg::ST_RESET;
		end else if (tck_rise_i) begin
			state_o <= state_nxt;
		end
	end

endmodule : tap_fsm

// file: rtl/jtag_tap_instruction_unit.sv
/*
 * Test access port front end of a configuration memory: instruction register
 * capture/shift/update, decode, bypass/ID/user-code data paths, high-Z, clamp,
 * configuration trigger pulse and, in the 16-bit variant only, design revision reset.
 * Assumes TCK, TMS, TDI and the status levels arrive asynchronously; all logic
 * runs on ref_clk_i, which must be several times faster than TCK.
 */
//
// Behaviour
// R1: Narrow codes: FF bypass, 01 sample, 00 extest
// R2: Wide codes: FFFF bypass, 0001 sample, 0000 extest
// R3: Clamp on FA / 00FA
// R4: FC / 00FC floats all outputs
// R5: FE / 00FE selects 32-bit ID register
// R6: FD / 00FD selects 32-bit user code
// R7: EE / 00EE pulses config trigger low once
// R8: Wide config also resets selected revision
// R9: Host pauses by stopping TCK, not Pause
// R10: Capture fixed pattern, shift out LSB first
// R11: Narrow instruction register is eight bits
// R12: Narrow capture: 7:5,2 zero; 1:0 01
// R13: Narrow bit 4 shows config mode
// R14: Narrow bit 3 shows read security
// R15: Wide instruction register is sixteen bits
// R16: Wide capture bits 15:9 zero
// R17: Wide 8:7 config result 10/01
// R18: Wide 6:5 erase/program result 10/01
// R19: Wide bit 4 is erase/program idle
// R20: Wide bit 3 shows config mode
// R21: Wide bit 2 shows revision done
// R22: Wide capture bits 1:0 are 01
// R23: Config mode: cascade high, outputs off, inputs ignored
// R24: ID register bit 0 always 1
// R25: Blank user code reads all ones
// R26: Standard sixteen-state controller on TCK rise
// R27: Unknown codes select one-bit bypass
`timescale 1ns/10ps
module jtag_tap_instruction_unit #(
	parameter int IR_WIDTH = 16,
	parameter logic [31:0] ID_CODE = tap_pkg::ID_CODE_DEFAULT
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	input wire logic insys_cfg_mode_flag_i,
	input wire logic read_secure_i,
	input wire logic [1:0] insys_cfg_result_i,
	input wire logic [1:0] erase_program_result_i,
	input wire logic erase_program_idle_i,
	input wire logic revision_done_i,
	input wire logic user_code_loaded_i,
	input wire logic [31:0] user_code_register_i,
	input wire logic [1:0] revision_select_pins_i,
	input wire logic [1:0] revision_bits_i,
	input wire logic use_ext_revision_i,
	output logic config_trigger_n_o,
	output logic revision_reset_o,
	output logic [1:0] revision_reset_sel_o,
	output logic cascade_enable_out_n_o,
	output logic outputs_highz_o,
	output logic outputs_clamp_o,
	output logic boundary_test_o,
	output logic inputs_ignored_o
);
	localparam bit WIDE = (IR_WIDTH == 16);

	logic [2:0] tck_s;
	logic tms_s;
	logic tdi_s;
	logic ctl_mode_s;
	logic ctl_secure_s;
	logic ctl_ep_idle_s;
	logic ctl_done_s;
	logic [1:0] ctl_cfg_res_s;
	logic [1:0] ctl_ep_res_s;
	logic [1:0] rev_pin_s;
	logic tck_prev_r;
	logic [1:0] warm_r;
	logic edges_ok;
	logic tck_rise;
	logic tck_fall;
	tap_pkg::tap_state_t state;
	logic [IR_WIDTH-1:0] ir_shift_r;
	tap_pkg::tap_op_t op_r;
	logic [31:0] dr_shift_r;
	logic config_done_r;

	// TAP pins, status levels and revision select pins pass two flops first
	pin_sync #(.WIDTH(3)) u_sync_tap (
		.clk_i(ref_clk_i),
		.rst_i(sys_rst_i),
		.async_i({tck_i, tms_i, tdi_i}),
		.sync_o(tck_s)
	);

	assign tms_s = tck_s[1];
	assign tdi_s = tck_s[0];

	pin_sync #(.WIDTH(10)) u_sync_status (
		.clk_i(ref_clk_i),
		.rst_i(sys_rst_i),
		.async_i({insys_cfg_mode_flag_i, read_secure_i, erase_program_idle_i,
			revision_done_i, insys_cfg_result_i, erase_program_result_i,
			revision_select_pins_i}),
		.sync_o({ctl_mode_s, ctl_secure_s, ctl_ep_idle_s, ctl_done_s,
			ctl_cfg_res_s, ctl_ep_res_s, rev_pin_s})
	);

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tck_prev_r <= 1'b0;
		end else begin
			tck_prev_r <= tck_s[2];
		end
	end

	// Sync pipe and edge flop refill after reset; no false edge meanwhile
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			warm_r <= 2'h0;
		end else if (!edges_ok) begin
			warm_r <= warm_r + 2'h1;
		end
	end

	assign edges_ok = (32'(warm_r) > tap_pkg::SYNC_STAGES);
	assign tck_rise = tck_s[2] & ~tck_prev_r & edges_ok;
	assign tck_fall = ~tck_s[2] & tck_prev_r & edges_ok;

	tap_fsm u_fsm (
		.clk_i(ref_clk_i),
		.rst_i(sys_rst_i),
		.tck_rise_i(tck_rise),
		.tms_i(tms_s),
		.state_o(state)
	); // R26

	function automatic tap_pkg::tap_op_t decode_op(input logic [IR_WIDTH-1:0] code);
		logic [15:0] wide;
		logic [7:0] lo;
		logic hi_zero;
		// Narrow codes pad with zeros, so the upper byte check always passes
		wide = 16'(code);
		lo = wide[7:0];
		hi_zero = (wide[15:8] == 8'h00);
		decode_op = tap_pkg::OP_BYPASS; // R27
		if (hi_zero) begin
			unique case (lo)
				tap_pkg::CODE_SAMPLE: decode_op = tap_pkg::OP_SAMPLE; // R1 R2
				tap_pkg::CODE_EXTEST: decode_op = tap_pkg::OP_EXTEST; // R1 R2
				tap_pkg::CODE_CLAMP: decode_op = tap_pkg::OP_CLAMP; // R3
				tap_pkg::CODE_HIGHZ: decode_op = tap_pkg::OP_HIGHZ; // R4
				tap_pkg::CODE_IDCODE: decode_op = tap_pkg::OP_IDCODE; // R5
				tap_pkg::CODE_USER_CODE_REGISTER: decode_op = tap_pkg::OP_USER_CODE_REGISTER; // R6
				tap_pkg::CODE_CONFIG: decode_op = tap_pkg::OP_CONFIG; // R7
				default: decode_op = tap_pkg::OP_BYPASS; // R1 R2 R27
			endcase
		end
	endfunction : decode_op

	function automatic logic [IR_WIDTH-1:0] capture_word();
		logic [15:0] w;
		w = 16'h0000; // R12 R16
		if (IR_WIDTH == 8) begin
			w[4] = ctl_mode_s; // R13
			w[3] = ctl_secure_s; // R14
		end else begin
			w[8:7] = ctl_cfg_res_s; // R17
			w[6:5] = ctl_ep_res_s; // R18
			w[4] = ctl_ep_idle_s; // R19
			w[3] = ctl_mode_s; // R20
			w[2] = ctl_done_s; // R21
		end
		w[1:0] = tap_pkg::CAP_LSB_PATTERN; // R12 R22
		capture_word = w[IR_WIDTH-1:0];
	endfunction : capture_word

	// Instruction register capture and LSB-first shift
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ir_shift_r <= '0;
		end else if (tck_rise) begin
			if (state == tap_pkg::ST_CAP_IR) begin
				ir_shift_r <= capture_word(); // R10 R11 R15
			end else if (state == tap_pkg::ST_SHIFT_IR) begin
				ir_shift_r <= {tdi_s, ir_shift_r[IR_WIDTH-1:1]}; // R10
			end
		end
	end

	// Active instruction; test-logic-reset selects the identification path
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			op_r <= tap_pkg::OP_IDCODE;
		end else if (tck_fall) begin
			if (state == tap_pkg::ST_RESET) begin
				op_r <= tap_pkg::OP_IDCODE;
			end else if (state == tap_pkg::ST_UPD_IR) begin
				op_r <= decode_op(ir_shift_r);
			end
		end
	end

	// Data register path: 1-bit bypass, or 32-bit ID / user code
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			dr_shift_r <= '0;
		end else if (tck_rise) begin
			if (state == tap_pkg::ST_CAP_DR) begin
				unique case (op_r)
					tap_pkg::OP_IDCODE: dr_shift_r <= {ID_CODE[31:1], 1'b1}; // R5 R24
					tap_pkg::OP_USER_CODE_REGISTER: dr_shift_r <= user_code_loaded_i ?
						user_code_register_i : tap_pkg::USER_CODE_BLANK; // R6 R25
					default: dr_shift_r <= '0; // R27
				endcase
			end else if (state == tap_pkg::ST_SHIFT_DR) begin
				if (op_r == tap_pkg::OP_IDCODE || op_r == tap_pkg::OP_USER_CODE_REGISTER) begin
					dr_shift_r <= {tdi_s, dr_shift_r[31:1]};
				end else begin
					dr_shift_r <= {31'h0, tdi_s}; // R27
				end
			end
		end
	end

	// TDO changes on the falling TCK edge, driven only while shifting
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tdo_o <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe_o <= (state == tap_pkg::ST_SHIFT_IR) || (state == tap_pkg::ST_SHIFT_DR);
			tdo_o <= (state == tap_pkg::ST_SHIFT_IR) ? ir_shift_r[0] : dr_shift_r[0]; // R10
		end
	end

	// One low pulse on config trigger at the first Idle after the active instruction turns to config
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			config_trigger_n_o <= 1'b1;
			revision_reset_o <= 1'b0;
			revision_reset_sel_o <= tap_pkg::REV_RESET;
			config_done_r <= 1'b0;
		end else begin
			config_trigger_n_o <= 1'b1;
			revision_reset_o <= 1'b0;
			if (op_r != tap_pkg::OP_CONFIG) begin
				config_done_r <= 1'b0;
			end else if (!config_done_r && state == tap_pkg::ST_IDLE) begin
				config_done_r <= 1'b1;
				config_trigger_n_o <= 1'b0; // R7
				if (WIDE) begin
					revision_reset_o <= 1'b1; // R8
					revision_reset_sel_o <= use_ext_revision_i ?
						rev_pin_s : revision_bits_i; // R8
				end
			end
		end
	end

	// Pin control; programming mode forces cascade high and quiets outputs
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			outputs_highz_o <= 1'b0;
		end else begin
			outputs_highz_o <= (op_r == tap_pkg::OP_HIGHZ) || ctl_mode_s; // R4 R23
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			outputs_clamp_o <= 1'b0;
		end else begin
			outputs_clamp_o <= (op_r == tap_pkg::OP_CLAMP); // R3
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			boundary_test_o <= 1'b0;
		end else begin
			boundary_test_o <= (op_r == tap_pkg::OP_EXTEST) || (op_r == tap_pkg::OP_CLAMP);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			inputs_ignored_o <= 1'b0;
		end else begin
			inputs_ignored_o <= ctl_mode_s; // R23
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			cascade_enable_out_n_o <= 1'b1;
		end else begin
			cascade_enable_out_n_o <= ctl_mode_s ? 1'b1 : 1'b0; // R23
		end
	end

endmodule : jtag_tap_instruction_unit

// file: testbench/tap_checker.sv
/* Port checks for the TAP instruction unit.
   Assumes the 16-bit variant, bound by the bench top. */
`timescale 1ns/10ps
module tap_checker (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic tck_i,
	input wire logic insys_cfg_mode_flag_i,
	input wire logic tdo_o,
	input wire logic tdo_oe_o,
	input wire logic config_trigger_n_o,
	input wire logic revision_reset_o,
	input wire logic [1:0] revision_reset_sel_o,
	input wire logic cascade_enable_out_n_o,
	input wire logic outputs_highz_o,
	input wire logic outputs_clamp_o,
	input wire logic boundary_test_o,
	input wire logic inputs_ignored_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_trig_single: assert property (!config_trigger_n_o |=> config_trigger_n_o)
		else $error("trigger pulse too long");
	a_trig_spaced: assert property (!config_trigger_n_o |=> config_trigger_n_o[*8])
		else $error("trigger pulsed twice");
	a_rev_pair: assert property (config_trigger_n_o != revision_reset_o)
		else $error("revision reset apart from trigger");
	a_sel_hold: assert property ($changed(revision_reset_sel_o) |-> revision_reset_o)
		else $error("revision choice moved without reset");
	a_tdo_on_fall: assert property ($changed(tdo_o) |-> !tck_i)
		else $error("tdo moved while tck high");
	a_oe_on_fall: assert property ($changed(tdo_oe_o) |-> !tck_i)
		else $error("tdo enable moved while tck high");
	a_cfg_mode_on: assert property (insys_cfg_mode_flag_i[*5] |->
		cascade_enable_out_n_o && inputs_ignored_o && outputs_highz_o)
		else $error("config mode outputs wrong");
	a_cfg_mode_off: assert property ((!insys_cfg_mode_flag_i)[*5] |->
		!cascade_enable_out_n_o && !inputs_ignored_o)
		else $error("normal mode outputs wrong");
	a_clamp_test: assert property (outputs_clamp_o |-> boundary_test_o)
		else $error("clamp without boundary test");
endmodule : tap_checker

// file: testbench/jtag_host.sv
/* JTAG host model driving TCK, TMS and TDI and sampling TDO.
   Assumes calls start on a falling edge of the system clock. */
`timescale 1ns/10ps
module jtag_host (
	input wire logic tdo_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	initial begin
		tck_o = 1'b1;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end
	// TMS and TDI stand 200 ns either side of the rise
	task step(input logic m, input logic d, output logic q);
		tck_o = 1'b0;
		tms_o = m;
		tdi_o = d;
		#200;
		q = tdo_i;
		tck_o = 1'b1;
		#200;
	endtask : step
	task tap_reset();
		logic q;
		repeat (5) step(1'b1, ~tdi_o, q);
		step(1'b0, ~tdi_o, q);
	endtask : tap_reset
	// Idle to Idle; shift paused never, no Pause states
	task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		step(1'b1, ~tdi_o, q);
		if (ir) step(1'b1, ~tdi_o, q);
		step(1'b0, ~tdi_o, q);
		step(1'b0, ~tdi_o, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~tdi_o, q);
		step(1'b0, ~tdi_o, q);
	endtask : scan
endmodule : jtag_host

// file: testbench/jtag_tap_instruction_unit_tb.sv
/* Bench for the TAP instruction unit with a host model.
   Assumes the 16-bit variant and a 20 MHz system clock. */
`timescale 1ns/10ps
module jtag_tap_instruction_unit_tb;
	localparam logic [31:0] ID = 32'h3c3c7001; // Arbitrary value
	logic ref_clk_i, sys_rst_i, tck, tms, tdi, tdo, mode, idle, done, uc_ok, use_ext;
	logic trig_n, rev_rst, casc, hz, clamp, btest, ign, oe;
	logic [1:0] cres, eres, rev_pins, rev_bits, rev_sel;
	logic [31:0] uc;
	int mismatches = 0;
	int compares = 0;
	int trig_cnt = 0;
	jtag_host host (.tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
	jtag_tap_instruction_unit #(.IR_WIDTH(16), .ID_CODE(ID)) dut (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms),
		.tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(oe), .insys_cfg_mode_flag_i(mode),
		.read_secure_i(1'b0), .insys_cfg_result_i(cres), .erase_program_result_i(eres),
		.erase_program_idle_i(idle), .revision_done_i(done), .user_code_loaded_i(uc_ok),
		.user_code_register_i(uc), .revision_select_pins_i(rev_pins),
		.revision_bits_i(rev_bits), .use_ext_revision_i(use_ext),
		.config_trigger_n_o(trig_n), .revision_reset_o(rev_rst),
		.revision_reset_sel_o(rev_sel), .cascade_enable_out_n_o(casc),
		.outputs_highz_o(hz), .outputs_clamp_o(clamp), .boundary_test_o(btest),
		.inputs_ignored_o(ign));
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) if (!trig_n) trig_cnt <= trig_cnt + 1;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task load(input logic [15:0] code);
		logic [31:0] d;
		host.scan(1'b1, 16, {16'h0, code}, d);
	endtask : load
	task t_capture(input logic [6:0] st, input logic [15:0] exp);
		logic [31:0] d;
		{mode, cres, eres, idle, done} = st;
		repeat (10) @(negedge ref_clk_i);
		host.scan(1'b1, 16, 32'hffff, d);
		chk(d, {16'h0, exp});
		chk({29'h0, casc, hz, ign}, {29'h0, {3{st[6]}}});
		$display("capture test done");
	endtask : t_capture
	task t_user();
		logic [31:0] d;
		load(16'h00fd);
		host.scan(1'b0, 32, 32'h0, d);
		chk(d, 32'hffffffff);
		uc_ok = 1'b1;
		host.scan(1'b0, 32, 32'h0, d);
		chk(d, uc);
		$display("user code test done");
	endtask : t_user
	task t_bypass(input logic [15:0] code);
		logic [31:0] d;
		load(code);
		host.scan(1'b0, 8, 32'ha5, d);
		chk(d, 32'h4a);
		$display("bypass test done");
	endtask : t_bypass
	task t_mode(input logic [15:0] code, input logic [2:0] exp);
		load(code);
		@(negedge ref_clk_i);
		chk({29'h0, hz, clamp, btest}, {29'h0, exp});
		chk({31'h0, oe}, 32'h0);
		$display("mode test done");
	endtask : t_mode
	task t_config(input logic ext, input logic [1:0] exp);
		int n;
		use_ext = ext;
		load(16'hffff);
		n = trig_cnt;
		load(16'h00ee);
		repeat (20) @(negedge ref_clk_i);
		chk(trig_cnt - n, 32'h1);
		chk({30'h0, rev_sel}, {30'h0, exp});
		$display("config test done");
	endtask : t_config
	task finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	initial begin
		#2000000;
		mismatches++;
		finish_test();
	end
	initial begin
		logic [31:0] d;
		sys_rst_i = 1'b1;
		{mode, cres, eres, idle, done, uc_ok, use_ext} = '0;
		uc = 32'h1234abcd;
		rev_pins = 2'h1;
		rev_bits = 2'h2;
		repeat (3) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		repeat (6) @(negedge ref_clk_i);
		host.tap_reset();
		host.scan(1'b0, 32, 32'h0, d);
		chk(d, ID);
		t_capture(7'b1011000, 16'h00c9);
		t_capture(7'b0100111, 16'h0135);
		t_user();
		t_bypass(16'hffff);
		t_bypass(16'h1234);
		t_mode(16'h0000, 3'h1);
		t_mode(16'h0001, 3'h0);
		t_mode(16'h00fa, 3'h3);
		t_mode(16'h00fc, 3'h4);
		t_config(1'b0, 2'h2);
		t_config(1'b1, 2'h1);
		finish_test();
	end
endmodule : jtag_tap_instruction_unit_tb
bind jtag_tap_instruction_unit tap_checker chk_i (.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i), .tck_i(tck_i), .insys_cfg_mode_flag_i(insys_cfg_mode_flag_i),
	.tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .config_trigger_n_o(config_trigger_n_o),
	.revision_reset_o(revision_reset_o), .revision_reset_sel_o(revision_reset_sel_o),
	.cascade_enable_out_n_o(cascade_enable_out_n_o), .outputs_highz_o(outputs_highz_o),
	.outputs_clamp_o(outputs_clamp_o), .boundary_test_o(boundary_test_o),
	.inputs_ignored_o(inputs_ignored_o));
